// ===== src/dll_loop_cfg.v
// loop bandwidth, loss-of-lock, detector, build-out and monitor controls of the digital PLL
`timescale 1ns/1ps
`default_nettype none
`include "dll_loop_defs.vh"

module dll_loop_cfg #(
   parameter [27:0] NE_TRY_CYCLES = `DLL_NE_TRY_CYC
) (
   // clock and reset
   input wire REF_CLK,
   input wire RST,
   // register port
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [7:0] REG_RDATA,
   // neighbouring control fields
   input wire [4:0] ACQ_BW_CODE,
   // loop status
   input wire LOOP_UPDATE,
   input wire LOCKED,
   input wire REF_SWITCH,
   input wire REF_ACTIVE,
   input wire FREQ_OVER_LIMIT,
   input wire FREQ_AT_LIMIT,
   input wire FINE_PHASE_OUT,
   input wire COARSE_PHASE_OUT,
   input wire [15:0] PHASE_MAG,
   // noise window
   input wire LOW_FREQ_INPUT,
   input wire REF_EDGE,
   input wire EDGE_IN_WINDOW,
   output reg REF_EDGE_OK,
   // frequency read-back
   input wire [15:0] FREQ_INST,
   input wire [15:0] FREQ_AVG_1S,
   input wire [15:0] FREQ_AVG_5M8,
   input wire [15:0] FREQ_AVG_93M2,
   output reg [15:0] FREQ_READ,
   // loop steering
   output reg [4:0] ACTIVE_BW_CODE,
   output reg [2:0] DAMPING_CODE,
   output reg LOSS_OF_LOCK,
   output reg [1:0] DET_SEL,
   output reg MULTICYCLE_PD_ON,
   output reg PHASE_CLIP_360,
   output reg INTEGRAL_FREEZE,
   output reg BUILD_OUT,
   output reg ZERO_PHASE_LOCK,
   output reg PHASE_ALARM
);

   // detector choices on DET_SEL
   localparam [1:0] DET_HALF_PD = 2'b00;
   localparam [1:0] DET_HALF_PFD = 2'b01;
   localparam [1:0] DET_FULL_PFD = 2'b10;

   // locking mode states
   localparam [1:0] ST_FULL = 2'b00;
   localparam [1:0] ST_TRY = 2'b01;
   localparam [1:0] ST_NEAREST = 2'b10;

   // software-visible registers
   reg [7:0] lbw_reg;
   reg [7:0] llc_reg;
   reg [7:0] lbb_reg;
   reg [7:0] pmc_reg;

   // copies the loop actually uses
   reg [7:0] lbw_act_reg;
   reg [7:0] llc_act_reg;
   reg [7:0] lbb_act_reg;
   reg [7:0] pmc_act_reg;

   reg [1:0] mode_reg;
   reg [1:0] mode_next;
   reg alarm_prev_reg;

   wire [4:0] locked_bw_code;
   wire [2:0] locked_damping_code;
   wire no_activity_lol_en;
   wire freq_limit_lol_en;
   wire fine_limit_en;
   wire coarse_limit_en;
   wire multicycle_pd_en;
   wire multicycle_in_loop;
   wire nearest_edge_disable;
   wire half_cycle_detector_select;
   wire auto_bw_select;
   wire integral_clamp_en;
   wire build_out_en;
   wire build_out_freeze;
   wire [1:0] freq_read_select;
   wire noise_window_en;
   wire phase_monitor_en;
   wire monitor_build_out_en;
   wire [3:0] phase_monitor_limit;
   wire [13:0] pm_limit_qns;
   wire lol_any;
   wire alarm_now;
   wire try_start;
   wire try_stop;
   wire try_done;

   // unused codes above 400 Hz run at 400 Hz rather than an undefined rate
   function [4:0] bw_sat;
      input [4:0] code;
      begin
         bw_sat = (code > `DLL_BW_MAX) ? `DLL_BW_MAX : code;
      end
   endfunction

   assign locked_bw_code = lbw_act_reg[`DLL_BW_HI:`DLL_BW_LO];
   assign locked_damping_code = lbw_act_reg[7:5];
   assign no_activity_lol_en = llc_act_reg[`DLL_NA_LOL];
   assign freq_limit_lol_en = llc_act_reg[`DLL_FL_LOL];
   assign fine_limit_en = llc_act_reg[`DLL_FINE_EN];
   assign coarse_limit_en = llc_act_reg[`DLL_COARSE_EN];
   assign multicycle_pd_en = llc_act_reg[`DLL_MC_PD_EN];
   assign multicycle_in_loop = llc_act_reg[`DLL_MC_IN_LOOP];
   assign nearest_edge_disable = llc_act_reg[`DLL_NE_DIS];
   assign half_cycle_detector_select = llc_act_reg[`DLL_HC_SEL];
   assign auto_bw_select = lbb_act_reg[`DLL_AUTO_BW];
   assign integral_clamp_en = lbb_act_reg[`DLL_INT_CLAMP];
   assign build_out_en = lbb_act_reg[`DLL_BO_EN];
   assign build_out_freeze = lbb_act_reg[`DLL_BO_FRZ];
   assign freq_read_select = lbb_act_reg[`DLL_RD_SEL_HI:`DLL_RD_SEL_LO];
   assign noise_window_en = pmc_act_reg[`DLL_NW_EN];
   assign phase_monitor_en = pmc_act_reg[`DLL_PM_EN];
   assign monitor_build_out_en = pmc_act_reg[`DLL_PM_BO_EN];
   assign phase_monitor_limit = pmc_act_reg[`DLL_PM_LIM_HI:`DLL_PM_LIM_LO];

   assign pm_limit_qns = ({10'h000, phase_monitor_limit} + `DLL_PM_OFFSET) * `DLL_PM_STEP_QNS;
   assign alarm_now = phase_monitor_en && (PHASE_MAG > {2'b00, pm_limit_qns});

   assign lol_any = (no_activity_lol_en && !REF_ACTIVE)
      || (freq_limit_lol_en && FREQ_OVER_LIMIT)
      || (fine_limit_en && FINE_PHASE_OUT)
      || (coarse_limit_en && COARSE_PHASE_OUT);

   assign try_start = REF_SWITCH && !nearest_edge_disable;
   assign try_stop = (mode_reg != ST_TRY) || lol_any || LOCKED;

   dll_try_timer #(
      .CYCLES(NE_TRY_CYCLES)
   ) u_try_timer (
      .CLK(REF_CLK),
      .RST(RST),
      .START(try_start),
      .STOP(try_stop),
      .BUSY(),
      .DONE(try_done)
   );

   // register writes; reserved bits are masked off so they always read zero
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         lbw_reg <= `DLL_RST_LBW;
         llc_reg <= `DLL_RST_LLC;
         lbb_reg <= `DLL_RST_LBB;
         pmc_reg <= `DLL_RST_PMC;
      end
      else if (REG_WR)
      begin
         case (REG_ADDR)
            `DLL_ADDR_LBW: lbw_reg <= REG_WDATA & `DLL_MASK_LBW;
            `DLL_ADDR_LLC: llc_reg <= REG_WDATA & `DLL_MASK_LLC;
            `DLL_ADDR_LBB: lbb_reg <= REG_WDATA & `DLL_MASK_LBB;
            `DLL_ADDR_PMC: pmc_reg <= REG_WDATA & `DLL_MASK_PMC;
            default: lbw_reg <= lbw_reg;
         endcase
      end
   end

   // read data is registered; unmapped offsets answer zero
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         REG_RDATA <= 8'h00;
      end
      else if (REG_RD)
      begin
         case (REG_ADDR)
            `DLL_ADDR_LBW: REG_RDATA <= lbw_reg;
            `DLL_ADDR_LLC: REG_RDATA <= llc_reg;
            `DLL_ADDR_LBB: REG_RDATA <= lbb_reg;
            `DLL_ADDR_PMC: REG_RDATA <= pmc_reg;
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end

   // controls change only on a loop update so one computation never mixes settings
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         lbw_act_reg <= `DLL_RST_LBW;
         llc_act_reg <= `DLL_RST_LLC;
         lbb_act_reg <= `DLL_RST_LBB;
         pmc_act_reg <= `DLL_RST_PMC;
      end
      else if (LOOP_UPDATE)
      begin
         lbw_act_reg <= lbw_reg;
         llc_act_reg <= llc_reg;
         lbb_act_reg <= lbb_reg;
         pmc_act_reg <= pmc_reg;
      end
   end

   // locking mode sequence
   always @*
   begin
      mode_next = mode_reg;
      case (mode_reg)
         ST_FULL:
         begin
            if (try_start)
            begin
               mode_next = ST_TRY;
            end
         end
         ST_TRY:
         begin
            if (nearest_edge_disable || lol_any || try_done)
            begin
               mode_next = ST_FULL;
            end
            else if (LOCKED)
            begin
               mode_next = ST_NEAREST;
            end
         end
         ST_NEAREST:
         begin
            if (nearest_edge_disable || lol_any)
            begin
               mode_next = ST_FULL;
            end
            else if (try_start)
            begin
               mode_next = ST_TRY;
            end
         end
         default:
         begin
            mode_next = ST_FULL;
         end
      endcase
   end

   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         mode_reg <= ST_FULL;
      end
      else
      begin
         mode_reg <= mode_next;
      end
   end

   // loop steering outputs
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ACTIVE_BW_CODE <= 5'h0d;
         DAMPING_CODE <= 3'h3;
         LOSS_OF_LOCK <= 1'b0;
         DET_SEL <= DET_FULL_PFD;
         MULTICYCLE_PD_ON <= 1'b0;
         PHASE_CLIP_360 <= 1'b1;
         INTEGRAL_FREEZE <= 1'b0;
      end
      else
      begin
         if (auto_bw_select && !LOCKED)
         begin
            ACTIVE_BW_CODE <= bw_sat(ACQ_BW_CODE);
         end
         else
         begin
            ACTIVE_BW_CODE <= bw_sat(locked_bw_code);
         end
         DAMPING_CODE <= locked_damping_code;
         LOSS_OF_LOCK <= lol_any;
         if (nearest_edge_disable || (mode_next == ST_FULL))
         begin
            DET_SEL <= DET_FULL_PFD;
         end
         else if (half_cycle_detector_select)
         begin
            DET_SEL <= DET_HALF_PFD;
         end
         else
         begin
            DET_SEL <= DET_HALF_PD;
         end
         MULTICYCLE_PD_ON <= multicycle_pd_en;
         PHASE_CLIP_360 <= !multicycle_in_loop;
         INTEGRAL_FREEZE <= integral_clamp_en && FREQ_AT_LIMIT;
      end
   end

   // phase monitor alarm and build-out events
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         PHASE_ALARM <= 1'b0;
         alarm_prev_reg <= 1'b0;
         BUILD_OUT <= 1'b0;
         ZERO_PHASE_LOCK <= 1'b0;
      end
      else
      begin
         PHASE_ALARM <= alarm_now;
         alarm_prev_reg <= alarm_now;
         BUILD_OUT <= !build_out_freeze
            && ((build_out_en && REF_SWITCH)
            || (monitor_build_out_en && alarm_now && !alarm_prev_reg));
         ZERO_PHASE_LOCK <= REF_SWITCH && !build_out_en && !build_out_freeze;
      end
   end

   // frequency read-back and edge qualification
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         FREQ_READ <= 16'h0000;
         REF_EDGE_OK <= 1'b0;
      end
      else
      begin
         case (freq_read_select)
            2'b00: FREQ_READ <= FREQ_INST;
            2'b01: FREQ_READ <= FREQ_AVG_1S;
            2'b10: FREQ_READ <= FREQ_AVG_5M8;
            2'b11: FREQ_READ <= FREQ_AVG_93M2;
            default: FREQ_READ <= FREQ_INST;
         endcase
         // noise window filter
         // window only applies while locked with nearest-edge locking enabled on a slow input
         if (noise_window_en && LOW_FREQ_INPUT && LOCKED && !nearest_edge_disable)
         begin
            REF_EDGE_OK <= REF_EDGE && EDGE_IN_WINDOW;
         end
         else
         begin
            REF_EDGE_OK <= REF_EDGE;
         end
      end
   end

endmodule // dll_loop_cfg

`default_nettype wire

// ===== src/dll_loop_defs.vh
// register map, field positions, reset values and timing counts for the loop controls
`ifndef DLL_LOOP_DEFS_VH
`define DLL_LOOP_DEFS_VH

// register offsets
`define DLL_ADDR_LBW 8'h74
`define DLL_ADDR_LLC 8'h75
`define DLL_ADDR_LBB 8'h76
`define DLL_ADDR_PMC 8'h78

// reset values
`define DLL_RST_LBW 8'h6d
`define DLL_RST_LLC 8'h70
`define DLL_RST_LBB 8'he0
`define DLL_RST_PMC 8'h06

// writable bit masks; reserved bits stay zero
`define DLL_MASK_LBW 8'hff
`define DLL_MASK_LLC 8'hff
`define DLL_MASK_LBB 8'hf3
`define DLL_MASK_PMC 8'hbf

// loop_lock_control fields
`define DLL_NA_LOL 7
`define DLL_FL_LOL 6
`define DLL_FINE_EN 5
`define DLL_COARSE_EN 4
`define DLL_MC_PD_EN 3
`define DLL_MC_IN_LOOP 2
`define DLL_NE_DIS 1
`define DLL_HC_SEL 0

// loop_bandwidth_buildout_control fields
`define DLL_AUTO_BW 7
`define DLL_INT_CLAMP 6
`define DLL_BO_EN 5
`define DLL_BO_FRZ 4
`define DLL_RD_SEL_HI 1
`define DLL_RD_SEL_LO 0

// phase_monitor_control fields
`define DLL_NW_EN 7
`define DLL_PM_EN 5
`define DLL_PM_BO_EN 4
`define DLL_PM_LIM_HI 3
`define DLL_PM_LIM_LO 0

// locked bandwidth code field and its top legal code (400 Hz)
`define DLL_BW_HI 4
`define DLL_BW_LO 0
`define DLL_BW_MAX 5'h14

// phase monitor: limit = (field + 7) * 156.25 ns, phase magnitude in 0.25 ns units
`define DLL_PM_OFFSET 14'h0007
`define DLL_PM_STEP_QNS 14'd625

// nearest-edge trial window: 2000 ms at 125000 kHz
`define DLL_NE_TRY_MS 28'd2000
`define DLL_CLK_KHZ 28'd125000
`define DLL_NE_TRY_CYC (`DLL_NE_TRY_MS * `DLL_CLK_KHZ)

`endif

// ===== src/dll_try_timer.v
// one-shot timer that bounds the nearest-edge locking trial
`timescale 1ns/1ps
`default_nettype none
`include "dll_loop_defs.vh"

module dll_try_timer #(
   parameter [27:0] CYCLES = `DLL_NE_TRY_CYC
) (
   // clock and reset
   input wire CLK,
   input wire RST,
   // control
   input wire START,
   input wire STOP,
   // status
   output wire BUSY,
   output reg DONE
);

   reg [27:0] count_reg;
   reg busy_reg;

   assign BUSY = busy_reg;

   // start wins over stop so a new reference always gets a full window
   always @(posedge CLK)
   begin
      if (RST)
      begin
         count_reg <= 28'h0000000;
         busy_reg <= 1'b0;
         DONE <= 1'b0;
      end
      else
      begin
         DONE <= 1'b0;
         if (START)
         begin
            count_reg <= 28'h0000001;
            busy_reg <= 1'b1;
         end
         else if (STOP)
         begin
            busy_reg <= 1'b0;
         end
         else if (busy_reg)
         begin
            if (count_reg >= CYCLES)
            begin
               busy_reg <= 1'b0;
               DONE <= 1'b1;
            end
            else
            begin
               count_reg <= count_reg + 28'h0000001;
            end
         end
      end
   end

endmodule // dll_try_timer

`default_nettype wire

// ===== verif/dll_loop_chk_assertions.sv
// port-level assertions for the loop control block
`timescale 1ns/1ps
`default_nettype none
module dll_loop_chk #(
   parameter [27:0] NE_TRY_CYCLES = 28'd250000000
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // loop status
   input wire logic REF_SWITCH,
   input wire logic REF_ACTIVE,
   input wire logic FREQ_OVER_LIMIT,
   input wire logic FREQ_AT_LIMIT,
   input wire logic FINE_PHASE_OUT,
   input wire logic COARSE_PHASE_OUT,
   input wire logic [15:0] PHASE_MAG,
   input wire logic REF_EDGE,
   // loop steering
   input wire logic REF_EDGE_OK,
   input wire logic [4:0] ACTIVE_BW_CODE,
   input wire logic LOSS_OF_LOCK,
   input wire logic INTEGRAL_FREEZE,
   input wire logic BUILD_OUT,
   input wire logic ZERO_PHASE_LOCK,
   input wire logic PHASE_ALARM
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   sequence s_bo_pulse;
      BUILD_OUT ##1 !BUILD_OUT;
   endsequence
   property p_bw_range;
      ACTIVE_BW_CODE <= 5'h14;
   endproperty
   a_bw_range: assert property (p_bw_range) else $error("bw code too high");
   property p_lol_quiet;
      REF_ACTIVE && !FREQ_OVER_LIMIT && !FINE_PHASE_OUT && !COARSE_PHASE_OUT |=> !LOSS_OF_LOCK;
   endproperty
   a_lol_quiet: assert property (p_lol_quiet) else $error("lol without cause");
   property p_freeze_cause;
      !FREQ_AT_LIMIT |=> !INTEGRAL_FREEZE;
   endproperty
   a_freeze_cause: assert property (p_freeze_cause) else $error("freeze off limit");
   property p_bo_pulse;
      BUILD_OUT |-> s_bo_pulse;
   endproperty
   a_bo_pulse: assert property (p_bo_pulse) else $error("build-out too long");
   property p_bo_cause;
      BUILD_OUT |-> $past(REF_SWITCH) || PHASE_ALARM;
   endproperty
   a_bo_cause: assert property (p_bo_cause) else $error("build-out uncaused");
   property p_zero_lock;
      ZERO_PHASE_LOCK |-> !BUILD_OUT && $past(REF_SWITCH);
   endproperty
   a_zero_lock: assert property (p_zero_lock) else $error("zero lock uncaused");
   property p_alarm_low;
      $past(PHASE_MAG) <= 16'd4375 |-> !PHASE_ALARM;
   endproperty
   a_alarm_low: assert property (p_alarm_low) else $error("alarm below limit");
   property p_edge_ok;
      REF_EDGE_OK |-> $past(REF_EDGE);
   endproperty
   a_edge_ok: assert property (p_edge_ok) else $error("edge accepted uncaused");
endmodule // dll_loop_chk
bind dll_loop_cfg dll_loop_chk #(.NE_TRY_CYCLES(NE_TRY_CYCLES)) u_chk (.REF_CLK(REF_CLK),
   .RST(RST), .REF_SWITCH(REF_SWITCH), .REF_ACTIVE(REF_ACTIVE),
   .FREQ_OVER_LIMIT(FREQ_OVER_LIMIT), .FREQ_AT_LIMIT(FREQ_AT_LIMIT),
   .FINE_PHASE_OUT(FINE_PHASE_OUT), .COARSE_PHASE_OUT(COARSE_PHASE_OUT),
   .PHASE_MAG(PHASE_MAG), .REF_EDGE(REF_EDGE), .REF_EDGE_OK(REF_EDGE_OK),
   .ACTIVE_BW_CODE(ACTIVE_BW_CODE), .LOSS_OF_LOCK(LOSS_OF_LOCK),
   .INTEGRAL_FREEZE(INTEGRAL_FREEZE), .BUILD_OUT(BUILD_OUT),
   .ZERO_PHASE_LOCK(ZERO_PHASE_LOCK), .PHASE_ALARM(PHASE_ALARM));
`default_nettype wire

// ===== verif/dll_ref_model.sv
// behavioural source of the tracked reference clock
`timescale 1ns/1ps
`default_nettype none
module dll_ref_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench controls
   input wire logic run,
   input wire logic noisy,
   // reference view
   output logic edge_pulse,
   output logic active,
   output logic in_window
);
   logic [2:0] ph_reg;
   logic [1:0] cnt_reg;
   // activity, edges, window
   // window flag toggles between edges so a stale value never looks valid
   always @(negedge clk)
   begin
      active <= run && !rst;
      edge_pulse <= 1'b0;
      in_window <= !in_window;
      ph_reg <= (rst || !run) ? 3'h0 : ph_reg + 3'h1;
      if (rst)
      begin
         in_window <= 1'b0;
         cnt_reg <= 2'h0;
      end
      else if (run && ph_reg == 3'h7)
      begin
         edge_pulse <= 1'b1;
         cnt_reg <= cnt_reg + 2'h1;
         in_window <= !(noisy && cnt_reg == 2'h3);
      end
   end
endmodule // dll_ref_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam [27:0] TRY = 28'd50;
   logic REF_CLK = 1'b0, RST = 1'b1, we = 1'b0, re = 1'b0, lu = 1'b0, lk = 1'b0;
   logic sw = 1'b0, ov = 1'b0, al = 1'b0, fo = 1'b0, co = 1'b0, lf = 1'b0, run = 1'b1;
   logic exp_ok = 1'b0, mon = 1'b0, nw = 1'b0;
   logic [7:0] a = 8'h00, wd = 8'h00;
   logic [4:0] acq = 5'h0f;
   logic [15:0] mag = 16'h0000;
   logic [15:0] fq [4] = '{default: 16'h0000};
   logic [7:0] adrs [4] = '{8'h74, 8'h75, 8'h76, 8'h78};
   logic [7:0] rstv [4] = '{8'h6d, 8'h70, 8'he0, 8'h06};
   logic [7:0] msk [4] = '{8'hff, 8'hff, 8'hf3, 8'hbf};
   logic [7:0] bov [3] = '{8'h20, 8'h30, 8'h00};
   logic [4:0] bwc [4] = '{5'h00, 5'h14, 5'h15, 5'h1f};
   wire [7:0] rdat;
   wire [15:0] frd;
   wire [4:0] bw;
   wire [1:0] det;
   wire [2:0] dmp;
   wire eok, lol, mcp, clp, ifz, bo, zpl, alm, redg, ract, rwin;
   int failures = 0, compares = 0;
   integer seed = 3892;
   dll_loop_cfg #(.NE_TRY_CYCLES(TRY)) dut (.REF_CLK(REF_CLK), .RST(RST),
      .REG_ADDR(a), .REG_WDATA(wd), .REG_WR(we), .REG_RD(re), .REG_RDATA(rdat),
      .ACQ_BW_CODE(acq), .LOOP_UPDATE(lu), .LOCKED(lk), .REF_SWITCH(sw), .REF_ACTIVE(ract),
      .FREQ_OVER_LIMIT(ov), .FREQ_AT_LIMIT(al), .FINE_PHASE_OUT(fo), .COARSE_PHASE_OUT(co),
      .PHASE_MAG(mag), .LOW_FREQ_INPUT(lf), .REF_EDGE(redg), .EDGE_IN_WINDOW(rwin),
      .REF_EDGE_OK(eok), .FREQ_INST(fq[0]), .FREQ_AVG_1S(fq[1]), .FREQ_AVG_5M8(fq[2]),
      .FREQ_AVG_93M2(fq[3]), .FREQ_READ(frd), .ACTIVE_BW_CODE(bw), .DAMPING_CODE(dmp),
      .LOSS_OF_LOCK(lol), .DET_SEL(det), .MULTICYCLE_PD_ON(mcp), .PHASE_CLIP_360(clp),
      .INTEGRAL_FREEZE(ifz), .BUILD_OUT(bo), .ZERO_PHASE_LOCK(zpl), .PHASE_ALARM(alm));
   dll_ref_model ref_src (.clk(REF_CLK), .rst(RST), .run(run), .noisy(1'b1),
      .edge_pulse(redg), .active(ract), .in_window(rwin));
   always #4 REF_CLK = !REF_CLK;
   task automatic cmp(input logic [15:0] got, input logic [15:0] ex);
      compares++;
      if (got !== ex)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(negedge REF_CLK);
      a = ad;
      wd = d;
      we = 1'b1;
      @(negedge REF_CLK);
      we = 1'b0;
   endtask
   task automatic rc(input logic [7:0] ad, input logic [7:0] ex);
      @(negedge REF_CLK);
      a = ad;
      re = 1'b1;
      @(negedge REF_CLK);
      re = 1'b0;
      cmp(16'(rdat), 16'(ex));
   endtask
   // write, then let one loop update carry it to the outputs
   task automatic wu(input logic [7:0] ad, input logic [7:0] d);
      wr(ad, d);
      lu = 1'b1;
      @(negedge REF_CLK);
      lu = 1'b0;
      repeat (2) @(negedge REF_CLK);
   endtask
   task automatic swp;
      @(negedge REF_CLK);
      sw = 1'b1;
      @(negedge REF_CLK);
      sw = 1'b0;
   endtask
   function automatic logic [4:0] exp_bw(input logic [4:0] lc, ac, input logic au, l);
      logic [4:0] c;
      c = (au && !l) ? ac : lc;
      return (c > 5'h14) ? 5'h14 : c;
   endfunction
   always @(posedge REF_CLK)
      exp_ok <= redg && (rwin || !nw);
   always @(negedge REF_CLK)
      if (mon)
         cmp(16'(eok), 16'(exp_ok));
   initial
   begin
      logic [7:0] d;
      logic [3:0] lim;
      logic seen;
      int k;
      repeat (5) @(negedge REF_CLK);
      RST = 1'b0;
      for (int i = 0; i < 4; i++)
         rc(adrs[i], rstv[i]);
      cmp(16'(bw), 16'(exp_bw(5'h0d, acq, 1'b1, lk)));
      $display("test reset done");
      for (int i = 0; i < 12; i++)
      begin
         k = (i < 4) ? i : $unsigned($random(seed)) % 4;
         d = (i < 4) ? 8'hff : 8'($random(seed));
         wr(adrs[k], d);
         rc(adrs[k], d & msk[k]);
      end
      wr(8'h77, 8'hff);
      rc(8'h77, 8'h00);
      wr(8'h75, 8'h70);
      wr(8'h78, 8'h06);
      $display("test registers done");
      for (int n = 0; n < 16; n++)
      begin
         d[4:0] = (n < 8) ? bwc[n % 4] : 5'($random(seed));
         acq = 5'($unsigned($random(seed)) % 21);
         lk = n[0];
         wr(8'h74, {n[0], 2'b01, d[4:0]});
         wu(8'h76, {n[2], 7'h00});
         cmp(16'(bw), 16'(exp_bw(d[4:0], acq, n[2], n[0])));
         cmp(16'(dmp), 16'({n[0], 2'b01}));
      end
      $display("test bandwidth done");
      for (int e = 0; e < 4; e++)
      begin
         wu(8'h75, 8'h80 >> e);
         for (int c = 0; c < 4; c++)
         begin
            run = (c != 0);
            ov = (c == 1);
            fo = (c == 2);
            co = (c == 3);
            repeat (4) @(negedge REF_CLK);
            cmp(16'(lol), 16'(e == c));
         end
      end
      run = 1'b1;
      co = 1'b0;
      $display("test loss of lock done");
      for (int m = 0; m < 4; m++)
      begin
         wu(8'h75, {4'h0, m[1] | m[0], m[0], 2'b00});
         cmp(16'(mcp), 16'(m[1] | m[0]));
         cmp(16'(clp), 16'(!m[0]));
      end
      wr(8'h75, 8'h00);
      repeat (3) @(negedge REF_CLK);
      cmp(16'(clp), 16'h0000);
      wu(8'h75, 8'h00);
      cmp(16'(clp), 16'h0001);
      for (int s = 0; s < 4; s++)
      begin
         for (int j = 0; j < 4; j++)
            fq[j] = 16'($random(seed));
         al = s[0];
         wu(8'h76, {1'b0, s[1], 4'h0, s[1:0]});
         cmp(frd, fq[s]);
         cmp(16'(ifz), 16'(s[0] & s[1]));
      end
      al = 1'b0;
      lk = 1'b0;
      $display("test detector and read done");
      for (int b = 0; b < 3; b++)
      begin
         wu(8'h76, bov[b]);
         swp();
         cmp(16'(bo), 16'(b == 0));
         cmp(16'(zpl), 16'(b == 2));
         cmp(16'(det), 16'h0000);
         @(negedge REF_CLK);
         cmp(16'(bo), 16'h0000);
      end
      repeat (TRY + 5) @(negedge REF_CLK);
      cmp(16'(det), 16'h0002);
      wu(8'h75, 8'h01);
      swp();
      cmp(16'(det), 16'h0001);
      lk = 1'b1;
      repeat (TRY + 5) @(negedge REF_CLK);
      cmp(16'(det), 16'h0001);
      wu(8'h75, 8'h03);
      swp();
      cmp(16'(det), 16'h0002);
      $display("test build-out done");
      for (int l = 0; l < 4; l++)
      begin
         lim = (l < 2) ? {4{l[0]}} : 4'($random(seed));
         wu(8'h78, {3'h1, l[0], lim});
         mag = (16'(lim) + 16'd7) * 16'd625;
         repeat (2) @(negedge REF_CLK);
         cmp(16'(alm), 16'h0000);
         mag = mag + 16'd1;
         @(negedge REF_CLK);
         seen = bo;
         cmp(16'(alm), 16'h0001);
         @(negedge REF_CLK);
         seen = seen | bo;
         cmp(16'(seen), 16'(l[0]));
         mag = 16'h0000;
         repeat (2) @(negedge REF_CLK);
      end
      wu(8'h78, 8'h0f);
      mag = 16'hffff;
      repeat (2) @(negedge REF_CLK);
      cmp(16'(alm), 16'h0000);
      mag = 16'h0000;
      $display("test phase monitor done");
      lf = 1'b1;
      wu(8'h75, 8'h00);
      for (int w = 0; w < 2; w++)
      begin
         nw = w[0];
         wu(8'h78, {w[0], 7'h00});
         mon = 1'b1;
         repeat (80) @(negedge REF_CLK);
         mon = 1'b0;
      end
      $display("test noise window done");
      end_sim();
   end
   // about thirty times the expected length of all tests
   initial
   begin
      repeat (20000) @(posedge REF_CLK);
      failures++;
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
